// file: ccgic_pkg.sv
// What this block does
// - Peripheral enable register is 8 bits; bit 7 gates the calendar clock, bits 6:0 drive other peripherals' enables.
// - Gate bit 0 stops the clock supply and ignores writes to clock registers.
// - Gate bit 1 supplies the clock and allows reads and writes of clock registers.
// - Clock control: run bit 7, 1 Hz enable 5, hour system 3, period 2:0.
// - Calendar counting halts while run bit is 0 and proceeds while it is 1.
// - Mask register bit 1: 0 lets the calendar interrupt be serviced, 1 blocks it.
// - Request register bit 1 is set when the calendar raises an interrupt request while the gate bit is 1.
// - Request flag reads 0 whenever no calendar request is pending.
package ccgic_pkg;

    localparam int AW = 4;
    localparam int DW = 8;

    // Register offsets
    localparam logic [AW-1:0] OFS_PERIPH_EN = 4'h0;
    localparam logic [AW-1:0] OFS_CLK_CTL   = 4'h1;
    localparam logic [AW-1:0] OFS_IRQ_MASK  = 4'h2;
    localparam logic [AW-1:0] OFS_IRQ_REQ   = 4'h3;
    localparam logic [AW-1:0] OFS_EVT_STAT  = 4'h4;
    localparam logic [AW-1:0] OFS_EVT_MASK  = 4'h5;

    // Reset values
    localparam logic [DW-1:0] RST_PERIPH_EN = 8'h00;
    localparam logic [DW-1:0] RST_CLK_CTL   = 8'h00;
    localparam logic [DW-1:0] RST_IRQ_MASK  = 8'hff;
    localparam logic [DW-1:0] RST_IRQ_REQ   = 8'h00;
    localparam logic [DW-1:0] RST_EVT_MASK  = 8'hff;

    // Field positions
    localparam int GATE_BIT     = 7;
    localparam int CAL_MASK_BIT = 1;
    localparam int CAL_REQ_BIT  = 1;

    // Writable bits of the clock control register; bits 6 and 4 stay zero
    localparam logic [DW-1:0] CLK_CTL_WMASK = 8'haf;

    // Sticky event status bits
    localparam int EVT_N       = 2;
    localparam int EVT_CAL_REQ = 0;
    localparam int EVT_REFUSED = 1;

    localparam logic [DW-1:0] ZERO = 8'h00;

    typedef struct packed {
        logic       run;
        logic       zero6;
        logic       one_hz_oe;
        logic       zero4;
        logic       hour24;
        logic [2:0] period;
    } ccgic_clk_ctl_s;

    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic          wr;
        logic          rd;
    } ccgic_bus_s;

endpackage : ccgic_pkg

// file: ccgic_top.sv
`timescale 1ns/1ps
module ccgic_top (
    // Clock and reset
    input  wire logic                       clock,
    input  wire logic                       nrst,
    // Register port
    input  wire ccgic_pkg::ccgic_bus_s      bus,
    output logic [ccgic_pkg::DW-1:0]        rdata,
    // Calendar core side
    input  wire logic                       sub_tick,
    input  wire logic                       cal_irq_req,
    input  wire logic                       one_hz_in,
    output logic                            cal_clk_en,
    output logic                            count_en,
    output logic                            rtc_wr_allow,
    output ccgic_pkg::ccgic_clk_ctl_s       clk_ctl,
    output logic                            one_hz_out,
    // Other peripherals' enables
    output logic [6:0]                      periph_en_other,
    // Interrupts
    output logic                            cal_service_req,
    output logic                            irq
);
    import ccgic_pkg::*;

    logic [DW-1:0]    periph_en_r;
    logic [DW-1:0]    clk_ctl_r;
    logic [DW-1:0]    irq_mask_r;
    logic [DW-1:0]    irq_req_r;
    logic [DW-1:0]    irq_req_nxt;
    logic [EVT_N-1:0] evt_stat_r;
    logic [EVT_N-1:0] evt_mask_r;
    logic [DW-1:0]    rdata_r;
    logic [DW-1:0]    rd_mux;

    wire gate      = periph_en_r[GATE_BIT];
    wire wr_pe     = bus.wr && (bus.addr == OFS_PERIPH_EN);
    wire wr_cc_hit = bus.wr && (bus.addr == OFS_CLK_CTL);
    wire wr_cc     = wr_cc_hit && gate;
    wire wr_mk     = bus.wr && (bus.addr == OFS_IRQ_MASK);
    wire wr_if     = bus.wr && (bus.addr == OFS_IRQ_REQ);
    wire wr_em     = bus.wr && (bus.addr == OFS_EVT_MASK);
    wire rd_es     = bus.rd && (bus.addr == OFS_EVT_STAT);

    // Calendar requests only arise while the calendar is clocked
    wire cal_evt   = cal_irq_req && gate;

    wire [EVT_N-1:0] evt_in;
    assign evt_in[EVT_CAL_REQ] = cal_evt;
    assign evt_in[EVT_REFUSED] = wr_cc_hit && !gate;

    // Request flag: set wins over a software clear, write 1 leaves it
    always_comb begin
        irq_req_nxt = irq_req_r;
        if (wr_if) begin
            irq_req_nxt = bus.wdata;
            irq_req_nxt[CAL_REQ_BIT] = bus.wdata[CAL_REQ_BIT]
                                       && irq_req_r[CAL_REQ_BIT];
        end
        if (cal_evt) begin
            irq_req_nxt[CAL_REQ_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            periph_en_r <= RST_PERIPH_EN;
            clk_ctl_r   <= RST_CLK_CTL;
            irq_mask_r  <= RST_IRQ_MASK;
            irq_req_r   <= RST_IRQ_REQ;
        end else begin
            if (wr_pe) begin
                periph_en_r <= bus.wdata;
            end
            if (wr_cc) begin
                clk_ctl_r <= bus.wdata & CLK_CTL_WMASK;
            end
            if (wr_mk) begin
                irq_mask_r <= bus.wdata;
            end
            irq_req_r <= irq_req_nxt;
        end
    end

    // Sticky event status, cleared by reading it; a new event wins
    genvar g;
    generate
        for (g = 0; g < EVT_N; g++) begin : g_evt
            always_ff @(posedge clock) begin
                if (!nrst) begin
                    evt_stat_r[g] <= 1'b0;
                    evt_mask_r[g] <= RST_EVT_MASK[g];
                end else begin
                    evt_stat_r[g] <= evt_in[g] || (evt_stat_r[g] && !rd_es);
                    if (wr_em) begin
                        evt_mask_r[g] <= bus.wdata[g];
                    end
                end
            end
        end
    endgenerate

    always_comb begin
        rd_mux = ZERO;
        unique case (bus.addr)
            OFS_PERIPH_EN: rd_mux = periph_en_r;
            OFS_CLK_CTL:   rd_mux = clk_ctl_r;
            OFS_IRQ_MASK:  rd_mux = irq_mask_r;
            OFS_IRQ_REQ:   rd_mux = irq_req_r;
            OFS_EVT_STAT:  rd_mux = {{(DW-EVT_N){1'b0}}, evt_stat_r};
            OFS_EVT_MASK:  rd_mux = {{(DW-EVT_N){1'b0}}, evt_mask_r};
            default:       rd_mux = ZERO;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            rdata_r <= ZERO;
        end else if (bus.rd) begin
            rdata_r <= rd_mux;
        end
    end

    assign rdata           = rdata_r;
    assign clk_ctl         = ccgic_clk_ctl_s'(clk_ctl_r);
    assign cal_clk_en      = sub_tick && gate;
    assign count_en        = cal_clk_en && clk_ctl.run;
    assign rtc_wr_allow    = gate;
    assign one_hz_out      = one_hz_in && gate && clk_ctl.one_hz_oe;
    assign periph_en_other = periph_en_r[GATE_BIT-1:0];
    assign cal_service_req = irq_req_r[CAL_REQ_BIT]
                             && !irq_mask_r[CAL_MASK_BIT];
    assign irq             = |(evt_stat_r & ~evt_mask_r);

endmodule : ccgic_top

// file: ccgic_top_chk.sv
`timescale 1ns/1ps
module ccgic_chk (
    // Clock and reset
    input logic                     clock,
    input logic                     nrst,
    // Register port
    input ccgic_pkg::ccgic_bus_s    bus,
    // Calendar side
    input logic                     sub_tick,
    input logic                     cal_irq_req,
    input logic                     cal_clk_en,
    input logic                     count_en,
    input logic                     rtc_wr_allow,
    input ccgic_pkg::ccgic_clk_ctl_s clk_ctl,
    input logic                     cal_service_req
);
    import ccgic_pkg::*;
    wire ctl_wr = bus.wr && bus.addr == OFS_CLK_CTL;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    a_gate_clock: assert property (cal_clk_en == (sub_tick & rtc_wr_allow))
        else $error("clock gate mismatch");
    a_run_count: assert property (count_en == (cal_clk_en & clk_ctl.run))
        else $error("count enable mismatch");
    a_zero_bits: assert property (!clk_ctl.zero6 && !clk_ctl.zero4)
        else $error("fixed zero bit set");
    a_gate_write: assert property (ctl_wr && !rtc_wr_allow |=> $stable(clk_ctl))
        else $error("gated write took effect");
    a_ctl_write: assert property (ctl_wr && rtc_wr_allow |=>
        clk_ctl == ($past(bus.wdata) & CLK_CTL_WMASK))
        else $error("control write lost");
    a_gate_set: assert property (bus.wr && bus.addr == OFS_PERIPH_EN |=>
        rtc_wr_allow == $past(bus.wdata[GATE_BIT]))
        else $error("gate bit not stored");
    a_flag_set: assert property ($rose(cal_service_req) |->
        $past(cal_irq_req) || $past(bus.wr))
        else $error("service request without cause");
    a_flag_hold: assert property (cal_service_req && !bus.wr |=> cal_service_req)
        else $error("service request dropped");
    c_service: cover property (cal_service_req);
    c_count: cover property (count_en);
    c_refused: cover property (ctl_wr && !rtc_wr_allow);
    c_set_wins: cover property (cal_irq_req && rtc_wr_allow && bus.wr && bus.addr == OFS_IRQ_REQ);
endmodule : ccgic_chk
bind ccgic_top ccgic_chk ccgic_chk_i (.*);

// file: test_calendar_clock_gate_and_irq_ctl.sv
`timescale 1ns/1ps
module test_calendar_clock_gate_and_irq_ctl;
    import ccgic_pkg::*;
    logic clock = 0, nrst = 0, sub_tick = 0, cal_irq_req = 0;
    ccgic_bus_s b = '0;
    logic [7:0] rdata;
    logic       cal_clk_en, count_en, cal_service_req, irq;
    logic       one_hz_in = 0;
    logic       rtc_wr_allow, one_hz_out;
    logic [6:0] periph_en_other;
    ccgic_clk_ctl_s clk_ctl;
    int         fail_count = 0, n_tests = 0;
    always #20 clock = ~clock;
    ccgic_top ccgic_top_i (.clock(clock), .nrst(nrst), .bus(b), .rdata(rdata),
        .sub_tick(sub_tick), .cal_irq_req(cal_irq_req), .one_hz_in(one_hz_in),
        .cal_clk_en(cal_clk_en), .count_en(count_en), .rtc_wr_allow(rtc_wr_allow),
        .clk_ctl(clk_ctl), .one_hz_out(one_hz_out), .periph_en_other(periph_en_other),
        .cal_service_req(cal_service_req), .irq(irq));
    task chk(string nm, logic [7:0] s, logic [7:0] e);
        n_tests++;
        if (s !== e) begin
            fail_count++;
            $display("[ERR] %s exp %h got %h", nm, e, s);
        end
    endtask : chk
    task wr(logic [3:0] a, logic [7:0] d);
        @(posedge clock) b <= '{a, d, 1'b1, 1'b0};
        @(posedge clock) b <= '{a, d, 1'b0, 1'b0};
        #1;
    endtask : wr
    task rd(logic [3:0] a, logic [7:0] e);
        @(posedge clock) b <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clock) b <= '{a, 8'h00, 1'b0, 1'b0};
        #1 chk("rdata", rdata, e);
    endtask : rd
    task pulse_req;
        @(posedge clock) cal_irq_req <= 1'b1;
        @(posedge clock) cal_irq_req <= 1'b0;
        #1;
    endtask : pulse_req
    task tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        rd(4'h0, 8'h00);
        rd(4'h2, 8'hff);
        rd(4'h3, 8'h00);
        rd(4'h7, 8'h00);
        chk("wr_allow", rtc_wr_allow, 8'h00);
        $display("reset values done");
        wr(4'h5, 8'h00);
        wr(4'h1, 8'hff);
        chk("irq", irq, 8'h01);
        rd(4'h1, 8'h00);
        rd(4'h4, 8'h02);
        chk("irq", irq, 8'h00);
        pulse_req();
        rd(4'h3, 8'h00);
        @(posedge clock) begin
            sub_tick  <= 1'b1;
            one_hz_in <= 1'b1;
        end
        #1 chk("clk_en", cal_clk_en, 8'h00);
        chk("one_hz", one_hz_out, 8'h00);
        $display("gate closed done");
        wr(4'h0, 8'h85);
        rd(4'h0, 8'h85);
        chk("wr_allow", rtc_wr_allow, 8'h01);
        chk("other_en", periph_en_other, 8'h05);
        chk("clk_en", cal_clk_en, 8'h01);
        wr(4'h1, 8'hff);
        rd(4'h1, 8'haf);
        chk("clk_ctl", clk_ctl, 8'haf);
        chk("one_hz", one_hz_out, 8'h01);
        chk("count_en", count_en, 8'h01);
        wr(4'h1, 8'h08);
        rd(4'h1, 8'h08);
        chk("one_hz", one_hz_out, 8'h00);
        chk("count_en", count_en, 8'h00);
        $display("gate open done");
        wr(4'h2, 8'hfd);
        pulse_req();
        chk("service", cal_service_req, 8'h01);
        chk("irq", irq, 8'h01);
        rd(4'h4, 8'h01);
        rd(4'h3, 8'h02);
        wr(4'h3, 8'h02);
        rd(4'h3, 8'h02);
        wr(4'h3, 8'h00);
        rd(4'h3, 8'h00);
        chk("service", cal_service_req, 8'h00);
        // A request and a software clear in the same cycle: the request wins
        @(posedge clock) begin
            cal_irq_req <= 1'b1;
            b           <= '{4'h3, 8'h00, 1'b1, 1'b0};
        end
        @(posedge clock) begin
            cal_irq_req <= 1'b0;
            b           <= '{4'h3, 8'h00, 1'b0, 1'b0};
        end
        #1 chk("set_wins", cal_service_req, 8'h01);
        wr(4'h2, 8'hff);
        chk("service", cal_service_req, 8'h00);
        rd(4'h3, 8'h02);
        wr(4'h3, 8'h00);
        rd(4'h3, 8'h00);
        $display("interrupt done");
        tally_and_finish();
    end
endmodule : test_calendar_clock_gate_and_irq_ctl
